// ===== verilog/bmi_exec_regs.svh
`ifndef BMI_EXEC_REGS_SVH
`define BMI_EXEC_REGS_SVH

// Opcode low bits shared by the three addressing forms; BMI_OP_START_IO is a whole opcode
`define BMI_OP_MOVE_IMM 6'h3C
`define BMI_OP_CLR 6'h3B
`define BMI_OP_SET 6'h3A
`define BMI_OP_SENSE 6'h30
`define BMI_OP_STORE_CPU 6'h3E
`define BMI_OP_START_IO 8'hF3
`define BMI_OP_ZN 4'h8

// Addressing mode codes in opcode bits 7:6 (operand 1) and bits 5:4 (operand 2)
`define BMI_AM_DIRECT 2'h0
`define BMI_AM_INDEX1 2'h1
`define BMI_AM_INDEX2 2'h2

// Program mode register bit positions (bit 0 is the LSB of the byte)
`define BMI_MODE_XL_OP1 6
`define BMI_MODE_XL_OP2 5

// Store-CPU selector codes
`define BMI_STORE_XLATE_A 4'h0
`define BMI_STORE_XLATE_B 4'h5
`define BMI_STORE_MODE 8'h40

// Translate entry fields
`define BMI_XLATE_GT64K 5
`define BMI_XLATE_DEPTH 32

// Sense selector that reads the panel switches
`define BMI_SENSE_PANEL 8'h00

`endif

// ===== verilog/bmi_exec_pkg.sv
package bmi_exec_pkg;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] q;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic [7:0] b6;
  } bmi_instr_s;

  typedef struct packed {
    logic [3:0] device_address_field;
    logic modifier;
    logic [2:0] fn;
    logic [7:0] ctrl;
    logic sense;
  } bmi_io_s;

  typedef enum logic [3:0] {
    BMI_IDLE, BMI_DEC, BMI_RD2, BMI_RD1, BMI_WR_LO, BMI_WR_HI, BMI_IO, BMI_START, BMI_DONE
  } bmi_state_e;

endpackage : bmi_exec_pkg

// ===== verilog/bmi_exec.sv
`include "bmi_exec_regs.svh"

module bmi_exec (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire bmi_exec_pkg::bmi_instr_s instr,
  input wire logic [15:0] index_register_one,
  input wire logic [15:0] index_register_two,
  input wire logic [7:0] program_mode_register,
  input wire logic privileged,
  input wire logic dual_prog_en,
  output logic mem_req,
  output logic mem_we,
  output logic [16:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic io_req,
  output bmi_exec_pkg::bmi_io_s io_cmd,
  output logic io_uc_clear,
  input wire logic io_ack,
  input wire logic [15:0] io_data,
  input wire logic io_is_local,
  input wire logic [2:0] io_ext,
  input wire logic io_busy,
  input wire logic io_not_ready,
  input wire logic io_uc_block,
  input wire logic io_uc_pending,
  input wire logic io_opend_reset,
  input wire logic [15:0] panel_sw,
  input wire logic xlate_we,
  input wire logic [4:0] xlate_idx,
  input wire logic [7:0] xlate_wdata,
  output logic mode_ext_we,
  output logic [2:0] mode_ext,
  output logic level_adv,
  output logic priv_fault,
  output logic done,
  output logic busy
);
  import bmi_exec_pkg::*;

  bmi_state_e state;
  bmi_instr_s ir;
  logic [15:0] ea1;
  logic [15:0] ea2;
  logic [7:0] opnd2;
  logic [15:0] wr_data;
  logic two_byte;
  logic [7:0] address_translate_entry [`BMI_XLATE_DEPTH];
  logic [15:0] panel_meta;
  logic [15:0] panel_sync;

  function automatic logic [15:0] bmi_ea(input logic [1:0] mode, input logic [7:0] hi, input logic [7:0] lo,
                                        input logic [15:0] x1, input logic [15:0] x2);
    logic [15:0] r;
    r = {hi, lo};
    if (mode == `BMI_AM_INDEX1) begin
      r = x1 + {8'h00, hi};
    end else if (mode == `BMI_AM_INDEX2) begin
      r = x2 + {8'h00, hi};
    end
    return r;
  endfunction : bmi_ea

  function automatic logic [16:0] bmi_phys(input logic [15:0] a, input logic en, input logic [7:0] e);
    logic [16:0] r;
    r = {1'b0, a};
    if (en) begin
      r = {e[`BMI_XLATE_GT64K], e[4:0], a[10:0]};
    end
    return r;
  endfunction : bmi_phys

  // Decode of the latched instruction
  wire [1:0] am1 = ir.op[7:6];
  wire [1:0] am2 = ir.op[5:4];
  wire is_zn = (ir.op[3:0] == `BMI_OP_ZN) && (am1 != 2'h3) && (am2 != 2'h3);
  wire is_imm = (ir.op[5:0] == `BMI_OP_MOVE_IMM) && (am1 != 2'h3);
  wire is_clr = (ir.op[5:0] == `BMI_OP_CLR) && (am1 != 2'h3);
  wire is_set = (ir.op[5:0] == `BMI_OP_SET) && (am1 != 2'h3);
  wire is_sense = (ir.op[5:0] == `BMI_OP_SENSE) && (am1 != 2'h3);
  wire is_store = (ir.op[5:0] == `BMI_OP_STORE_CPU) && (am1 != 2'h3);
  wire is_start = (ir.op == `BMI_OP_START_IO);

  // Operand addresses; operand 2 follows operand 1's address bytes
  wire [15:0] next_ea1 = bmi_ea(am1, ir.b3, ir.b4, index_register_one, index_register_two);
  wire [7:0] op2_hi = (am1 == `BMI_AM_DIRECT) ? ir.b5 : ir.b4;
  wire [7:0] op2_lo = (am1 == `BMI_AM_DIRECT) ? ir.b6 : ir.b5;
  wire [15:0] next_ea2 = bmi_ea(am2, op2_hi, op2_lo, index_register_one, index_register_two);

  // Translation enables; store-CPU operand cycles stay untranslated
  wire xl1 = program_mode_register[`BMI_MODE_XL_OP1] && !is_store;
  wire xl2 = program_mode_register[`BMI_MODE_XL_OP2];
  wire [15:0] ea1_m1 = ea1 - 16'h0001;
  wire [16:0] phys1 = bmi_phys(ea1, xl1, address_translate_entry[ea1[15:11]]);
  wire [16:0] phys1_m1 = bmi_phys(ea1_m1, xl1, address_translate_entry[ea1_m1[15:11]]);
  wire [16:0] phys2 = bmi_phys(ea2, xl2, address_translate_entry[ea2[15:11]]);

  // Zone/numeric move, selector bit 0 picks source nibble, bit 1 destination
  wire [3:0] zn_src = ir.q[0] ? opnd2[3:0] : opnd2[7:4];
  wire [7:0] zn_res = ir.q[1] ? {mem_rdata[7:4], zn_src} : {zn_src, mem_rdata[3:0]};
  wire [7:0] mod_res = is_clr ? (mem_rdata & ~ir.q) : (mem_rdata | ir.q);

  // Store-CPU source selection
  wire store_xlate = (ir.q[7:4] == `BMI_STORE_XLATE_A) || (ir.q[7:4] == `BMI_STORE_XLATE_B);
  wire [4:0] xlate_even = {ir.q[3:0], 1'b0};
  wire [4:0] xlate_odd = {ir.q[3:0], 1'b1};
  wire [15:0] store_data = store_xlate ? {address_translate_entry[xlate_odd], address_translate_entry[xlate_even]}
                         : (ir.q == `BMI_STORE_MODE) ? {program_mode_register, 8'h00} : 16'h0000;

  // Start I/O decisions
  wire start_wait = io_busy || io_not_ready;
  wire start_skip = io_uc_block && !io_opend_reset;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      panel_meta <= 16'h0000;
      panel_sync <= 16'h0000;
    end else begin
      panel_meta <= panel_sw;
      panel_sync <= panel_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (xlate_we) begin
      address_translate_entry[xlate_idx] <= xlate_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= BMI_IDLE;
      ir <= '0;
      ea1 <= 16'h0000;
      ea2 <= 16'h0000;
      opnd2 <= 8'h00;
      wr_data <= 16'h0000;
      two_byte <= 1'b0;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 17'h00000;
      mem_wdata <= 8'h00;
      io_req <= 1'b0;
      io_cmd <= '0;
      io_uc_clear <= 1'b0;
      mode_ext_we <= 1'b0;
      mode_ext <= 3'h0;
      level_adv <= 1'b0;
      priv_fault <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      io_req <= 1'b0;
      io_uc_clear <= 1'b0;
      mode_ext_we <= 1'b0;
      level_adv <= 1'b0;
      priv_fault <= 1'b0;
      done <= 1'b0;
      unique case (state)
        BMI_IDLE: begin
          if (start) begin
            ir <= instr;
            busy <= 1'b1;
            state <= BMI_DEC;
          end
        end
        BMI_DEC: begin
          ea1 <= next_ea1;
          ea2 <= next_ea2;
          state <= BMI_DONE;
          if (is_start) begin
            if (!privileged) begin
              priv_fault <= 1'b1;
            end else begin
              state <= BMI_START;
            end
          end else if (is_zn) begin
            state <= BMI_RD2;
          end else if (is_imm) begin
            wr_data <= {8'h00, ir.q};
            two_byte <= 1'b0;
            state <= BMI_WR_LO;
          end else if (is_clr || is_set) begin
            state <= BMI_RD1;
          end else if (is_sense) begin
            two_byte <= 1'b1;
            if (ir.q == `BMI_SENSE_PANEL) begin
              wr_data <= panel_sync;
              state <= BMI_WR_LO;
            end else begin
              io_req <= 1'b1;
              io_cmd <= {ir.q[7:4], ir.q[3], ir.q[2:0], 8'h00, 1'b1};
              state <= BMI_IO;
            end
          end else if (is_store) begin
            wr_data <= store_data;
            two_byte <= 1'b1;
            state <= BMI_WR_LO;
          end
        end
        BMI_RD2: begin
          mem_addr <= phys2;
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          if (mem_req && mem_ack) begin
            opnd2 <= mem_rdata;
            mem_req <= 1'b0;
            state <= BMI_RD1;
          end
        end
        BMI_RD1: begin
          mem_addr <= phys1;
          mem_req <= 1'b1;
          mem_we <= 1'b0;
          if (mem_req && mem_ack && mem_addr == phys1) begin
            wr_data <= {8'h00, is_zn ? zn_res : mod_res};
            two_byte <= 1'b0;
            mem_req <= 1'b0;
            state <= BMI_WR_LO;
          end
        end
        BMI_WR_LO: begin
          mem_addr <= phys1;
          mem_wdata <= wr_data[7:0];
          mem_we <= 1'b1;
          mem_req <= 1'b1;
          if (mem_req && mem_we && mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= two_byte ? BMI_WR_HI : BMI_DONE;
          end
        end
        BMI_WR_HI: begin
          mem_addr <= phys1_m1;
          mem_wdata <= wr_data[15:8];
          mem_we <= 1'b1;
          mem_req <= 1'b1;
          if (mem_req && mem_we && mem_ack && mem_addr == phys1_m1) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= BMI_DONE;
          end
        end
        BMI_IO: begin
          if (io_ack) begin
            wr_data <= io_data;
            if (io_is_local) begin
              mode_ext <= io_ext;
              mode_ext_we <= 1'b1;
            end
            state <= BMI_WR_LO;
          end
        end
        BMI_START: begin
          if (start_wait) begin
            if (dual_prog_en) begin
              level_adv <= 1'b1;
              state <= BMI_DONE;
            end
          end else if (start_skip) begin
            state <= BMI_DONE;
          end else begin
            io_req <= 1'b1;
            io_cmd <= {ir.q[7:4], ir.q[3], ir.q[2:0], ir.b3, 1'b0};
            io_uc_clear <= io_uc_pending && !io_uc_block;
            state <= BMI_DONE;
          end
        end
        BMI_DONE: begin
          done <= 1'b1;
          busy <= 1'b0;
          mem_req <= 1'b0;
          mem_we <= 1'b0;
          state <= BMI_IDLE;
        end
      endcase
    end
  end

endmodule : bmi_exec

// ===== dv/bmi_exec_asserts.sv
module bmi_exec_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic privileged,
  input wire logic dual_prog_en,
  input wire logic io_uc_block,
  input wire logic io_opend_reset,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_ack,
  input wire logic [16:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic io_req,
  input wire bmi_exec_pkg::bmi_io_s io_cmd,
  input wire logic io_uc_clear,
  input wire logic mode_ext_we,
  input wire logic level_adv,
  input wire logic priv_fault,
  input wire logic done,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  import bmi_exec_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_mem_wait;
    mem_req && !mem_ack;
  endsequence
  sequence s_mem_held;
    mem_req && $stable(mem_addr) && $stable(mem_wdata);
  endsequence
  a_mem_hold: assert property (s_mem_wait |=> s_mem_held)
    else $error("memory request changed before ack");
  a_start_take: assert property (start && !busy |=> busy)
    else $error("start not taken");
  a_done_end: assert property (done |-> !busy && $past(busy))
    else $error("done outside an instruction");
  a_we_req: assert property (mem_we |-> mem_req)
    else $error("write strobe without request");
  a_clear_start: assert property (io_uc_clear |-> io_req && !io_cmd.sense)
    else $error("unit check clear without start");
  a_fault_noio: assert property (priv_fault |-> !io_req && !privileged)
    else $error("privilege fault wrong");
  a_adv_dual: assert property (level_adv |-> dual_prog_en && !io_req)
    else $error("level advance without dual option");
  a_block_nop: assert property (io_req && !io_cmd.sense |-> !io_uc_block || io_opend_reset)
    else $error("start issued despite blocking check");
  a_req_pulse: assert property (io_req |=> !io_req)
    else $error("io request longer than a pulse");
  a_ext_pulse: assert property (mode_ext_we |=> !mode_ext_we)
    else $error("extension write longer than a pulse");
endmodule : bmi_exec_asserts

// ===== dv/bmi_exec_partner.sv
module bmi_exec_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [16:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack,
  input wire logic io_req,
  output logic io_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:131071];
  logic [2:0] wait_n;
  logic [1:0] io_n;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h5A;
      io_ack <= 1'b0;
      wait_n <= 3'h0;
      io_n <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      io_ack <= 1'b0;
      if (mem_req && !mem_ack && wait_n == 3'h0) begin
        mem_ack <= 1'b1;
        mem_rdata <= mem[mem_addr];
        if (mem_we) mem[mem_addr] <= mem_wdata;
        wait_n <= slow ? 3'h4 : 3'h0;
      end else if (mem_req && wait_n != 3'h0) wait_n <= wait_n - 3'h1;
      if (io_req) io_n <= 2'h2;
      else if (io_n != 2'h0) io_n <= io_n - 2'h1;
      if (io_n == 2'h1) io_ack <= 1'b1;
    end
  end
endmodule : bmi_exec_partner

// ===== dv/bmi_exec_tb_top.sv
module bmi_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bmi_exec_pkg::*;
  typedef struct packed {logic [7:0] op; logic [7:0] q; logic [15:0] a; logic [7:0] init; logic [7:0] exp;} bmi_row_s;
  logic clk = 1'b0, resetn = 1'b0, start = 1'b0, privileged = 1'b1, dual_prog_en = 1'b0, slow = 1'b0;
  logic io_is_local = 1'b0, io_busy = 1'b0, io_not_ready = 1'b0, io_uc_block = 1'b0, io_uc_pending = 1'b0;
  logic io_opend_reset = 1'b0, xlate_we = 1'b0;
  logic mem_req, mem_we, mem_ack, io_req, io_uc_clear, io_ack, mode_ext_we, level_adv, priv_fault, done, busy;
  logic [16:0] mem_addr;
  logic [15:0] ea;
  logic [7:0] mem_wdata, mem_rdata, program_mode_register = 8'h00, xlate_wdata = 8'h00;
  logic [2:0] mode_ext, last_ext, io_ext = 3'h5;
  logic [15:0] index_register_one = 16'h1000, index_register_two = 16'h2000;
  logic [15:0] io_data = 16'hABCD, panel_sw = 16'h1234;
  logic [4:0] xlate_idx = 5'h00;
  bmi_instr_s instr = 48'h0;
  bmi_io_s io_cmd, last_cmd;
  int n_errors = 0, check_count = 0, cyc = 0, n_io = 0, n_clr = 0, n_adv = 0, n_flt = 0, n_ext = 0;
  bmi_row_s rows [11] = '{
    '{8'h3C, 8'hAF, 16'h2FCB, 8'h00, 8'hAF}, '{8'h7C, 8'h3C, 16'h2000, 8'h11, 8'h3C},
    '{8'hBB, 8'h0F, 16'h4000, 8'hA5, 8'hA0}, '{8'h3B, 8'h01, 16'h0030, 8'h79, 8'h78},
    '{8'h3B, 8'hFF, 16'h0031, 8'hA5, 8'h00}, '{8'h3A, 8'h5A, 16'h0020, 8'h0C, 8'h5E},
    '{8'h7A, 8'h00, 16'h5000, 8'hA5, 8'hA5}, '{8'h08, 8'h00, 16'h1FC0, 8'h2F, 8'h4F},
    '{8'h08, 8'h01, 16'h1FC1, 8'h2F, 8'hCF}, '{8'h08, 8'h02, 16'h1FC2, 8'h2F, 8'h24},
    '{8'h08, 8'h03, 16'h1FC3, 8'h2F, 8'h2C}};
  bmi_exec uut (.clk, .resetn, .start, .instr, .index_register_one, .index_register_two, .program_mode_register,
    .privileged, .dual_prog_en, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .io_req, .io_cmd,
    .io_uc_clear, .io_ack, .io_data, .io_is_local, .io_ext, .io_busy, .io_not_ready, .io_uc_block, .io_uc_pending,
    .io_opend_reset, .panel_sw, .xlate_we, .xlate_idx, .xlate_wdata, .mode_ext_we, .mode_ext, .level_adv,
    .priv_fault,
    .done, .busy);
  bmi_exec_partner pm (.clk, .resetn, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .io_req, .io_ack);
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_io <= n_io + io_req;
    n_clr <= n_clr + io_uc_clear;
    n_adv <= n_adv + level_adv;
    n_flt <= n_flt + priv_fault;
    n_ext <= n_ext + mode_ext_we;
    if (io_req) last_cmd <= io_cmd;
    if (mode_ext_we) last_ext <= mode_ext;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic issue(input logic [47:0] i);
    @(posedge clk);
    start <= 1'b1;
    instr <= i;
    @(posedge clk);
    start <= 1'b0;
  endtask : issue
  task automatic wait_done(input int lim, input logic want);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < lim);
    check(done === 1'b1, want);
    @(posedge clk);
  endtask : wait_done
  task automatic run(input logic [47:0] i);
    issue(i);
    wait_done(300, 1'b1);
  endtask : run
  initial begin
    repeat (16) @(posedge clk);
    check({busy, done, mem_req, io_req, level_adv}, 0);
    resetn <= 1'b1;
    for (int e = 4; e < 7; e++) begin
      @(posedge clk);
      xlate_we <= 1'b1;
      xlate_idx <= e[4:0];
      xlate_wdata <= (e == 4) ? 8'h25 : (e == 5) ? 8'h1A : 8'h3F;
    end
    @(posedge clk);
    xlate_we <= 1'b0;
    foreach (rows[k]) begin
      ea = rows[k].op[7:6] == 2'h1 ? index_register_one + rows[k].a[15:8] :
        rows[k].op[7:6] == 2'h2 ? index_register_two + rows[k].a[15:8] : rows[k].a;
      pm.mem[{1'b0, ea}] = rows[k].init;
      pm.mem[17'h02B7A] = 8'h4C;
      slow <= k[0];
      run({rows[k].op, rows[k].q, rows[k].a, 16'h2B7A});
      check(pm.mem[{1'b0, ea}], rows[k].exp);
    end
    run({8'h30, 8'h00, 16'h05FF, 16'h0000});
    check({pm.mem[17'h005FE], pm.mem[17'h005FF], 8'h00, n_io[7:0]}, 32'h12340000);
    io_is_local <= 1'b1;
    run({8'h70, 8'hC5, 16'h4000, 16'h0000});
    check({pm.mem[17'h0103F], pm.mem[17'h01040]}, 16'hABCD);
    check({last_cmd.device_address_field, last_cmd.modifier, last_cmd.fn, last_cmd.sense}, 9'h18B);
    check({last_ext, n_ext[3:0]}, 7'h51);
    io_uc_pending <= 1'b1;
    run({8'hF3, 8'hA3, 8'h55, 24'h0});
    check({last_cmd, n_clr[3:0]}, {4'hA, 1'b0, 3'h3, 8'h55, 1'b0, 4'h1});
    io_uc_pending <= 1'b0;
    io_uc_block <= 1'b1;
    run({8'hF3, 8'hA3, 8'h55, 24'h0});
    check(n_io, 2);
    io_opend_reset <= 1'b1;
    run({8'hF3, 8'hA3, 8'h55, 24'h0});
    check(n_io, 3);
    io_uc_block <= 1'b0;
    io_opend_reset <= 1'b0;
    privileged <= 1'b0;
    run({8'hF3, 8'hA3, 8'h55, 24'h0});
    check({n_flt[3:0], n_io[3:0]}, 8'h13);
    privileged <= 1'b1;
    io_busy <= 1'b1;
    dual_prog_en <= 1'b1;
    run({8'hF3, 8'hA3, 8'h55, 24'h0});
    check({n_adv[3:0], n_io[3:0]}, 8'h13);
    io_busy <= 1'b0;
    io_not_ready <= 1'b1;
    dual_prog_en <= 1'b0;
    issue({8'hF3, 8'hA3, 8'h55, 24'h0});
    wait_done(10, 1'b0);
    io_not_ready <= 1'b0;
    wait_done(300, 1'b1);
    check(n_io, 4);
    program_mode_register <= 8'h40;
    run({8'h3E, 8'h02, 16'h3001, 16'h0000});
    check({pm.mem[17'h03000], pm.mem[17'h03001]}, 16'h1A25);
    run({8'h3E, 8'h40, 16'h3011, 16'h0000});
    check({pm.mem[17'h03010], pm.mem[17'h03011]}, 16'h4000);
    run({8'h3C, 8'h77, 16'h3005, 16'h0000});
    check(pm.mem[17'h1F805], 8'h77);
    program_mode_register <= 8'h00;
    issue({8'h3C, 8'h66, 16'h0040, 16'h0000});
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    check({busy, done, mem_req, mem_we, io_req}, 0);
    resetn <= 1'b1;
    run({8'h3C, 8'h99, 16'h0041, 16'h0000});
    check(pm.mem[17'h00041], 8'h99);
    close_out();
  end
endmodule : bmi_exec_tb_top
bind bmi_exec bmi_exec_asserts u_chk (.clk, .resetn, .start, .privileged, .dual_prog_en, .io_uc_block,
  .io_opend_reset, .mem_req, .mem_we, .mem_ack, .mem_addr, .mem_wdata, .io_req, .io_cmd, .io_uc_clear,
  .mode_ext_we, .level_adv, .priv_fault, .done, .busy);
